//--- fsp_pkg.sv
// ----------------------------------------------------------------------
// Shared constants for the flash security gate and clock prescaler
// ----------------------------------------------------------------------
`default_nettype none
package fsp_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets (one aligned word each, except the key block and flash window)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_PRESCALER  = 8'h00;  // flash_clock_prescaler
   localparam logic [7:0] OFS_OPTION     = 8'h04;  // working_option_register
   localparam logic [7:0] OFS_CONFIG     = 8'h08;  // flash_config_register
   localparam logic [7:0] OFS_PROTECTION = 8'h0c;  // working_protection_register
   localparam logic [7:0] OFS_STATUS     = 8'h10;  // error and state flags
   localparam logic [7:0] OFS_DEBUG      = 8'h14;  // debug module enable
   localparam logic [7:0] OFS_KEY_BASE   = 8'h20;  // eight key words 0x20..0x3c
   localparam logic [7:0] OFS_FLASH_BASE = 8'h80;  // flash array write window

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int PRESC_LOADED_BIT = 7;            // ratio_loaded_flag
   localparam int PRESC_BY8_BIT    = 6;            // prescale_by_eight
   localparam int OPT_BACKDOOR_BIT = 7;            // backdoor_enable
   localparam int CFG_KEY_ACCESS_MODE_BIT   = 5;            // key_access_mode
   localparam int STAT_ACCERR_BIT  = 0;            // access_error_flag, write 1 clears
   localparam int STAT_SECURED_BIT = 1;
   localparam int STAT_PGMEN_BIT   = 2;
   localparam int DBG_ENABLE_BIT   = 0;

   // ------------------------------------------------------------------
   // Codes, counts and reset values
   // ------------------------------------------------------------------
   localparam logic [1:0] SEC_UNSECURED  = 2'h2;   // only 1:0 is open
   localparam int         KEY_BYTES      = 8;
   localparam logic [2:0] PRESCALE_LAST  = 3'h7;   // divide by eight
   localparam logic [6:0] PRESC_RESET    = 7'h00;
   localparam logic [7:0] OPTION_RESET   = 8'hff;  // erased: secure until loaded
   localparam logic [7:0] PROT_RESET     = 8'hff;
   localparam logic [7:0] KEY_RESET      = 8'h00;

endpackage
`default_nettype wire

//--- fsp_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Flash timing clock divider: one strobe per flash clock period
// ----------------------------------------------------------------------
module fsp_clk_div (
   input  wire logic       hclk,              // Bus clock
   input  wire logic       hresetn,           // Async reset, active low
   input  wire logic       clk_en,            // Freezes all state when low
   input  wire logic       run,               // Divider loaded
   input  wire logic       prescale_by_eight, // Predivide by eight
   input  wire logic [5:0] ratio,             // Divide by ratio plus one
   output logic            timing_pulse       // One cycle per flash clock period
);

   logic [2:0] pre_cnt;
   logic [5:0] ratio_cnt;
   logic [2:0] next_pre_cnt;
   logic [5:0] next_ratio_cnt;
   logic       next_timing_pulse;
   logic       pre_tick;

   // Next counts; stopped counters restart cleanly once loaded
   always_comb begin
      next_pre_cnt      = pre_cnt;
      next_ratio_cnt    = ratio_cnt;
      next_timing_pulse = 1'b0;
      pre_tick          = !prescale_by_eight || (pre_cnt == fsp_pkg::PRESCALE_LAST);
      if (!run) begin
         next_pre_cnt   = 3'h0;
         next_ratio_cnt = 6'h00;
      end else begin
         next_pre_cnt = prescale_by_eight ? pre_cnt + 3'h1 : 3'h0;
         if (pre_tick) begin
            if (ratio_cnt == ratio) begin
               next_ratio_cnt    = 6'h00;
               next_timing_pulse = 1'b1;
            end else begin
               next_ratio_cnt = ratio_cnt + 6'h01;
            end
         end
      end
   end

   // Registers only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt      <= 3'h0;
         ratio_cnt    <= 6'h00;
         timing_pulse <= 1'b0;
      end else if (clk_en) begin
         pre_cnt      <= next_pre_cnt;
         ratio_cnt    <= next_ratio_cnt;
         timing_pulse <= next_timing_pulse;
      end
   end

endmodule
`default_nettype wire

//--- fsp_security.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Secured: unsecured-code or debug accesses to flash/RAM blocked, reads zero.
// - Code from secure memory always gets full access.
// - Unsecured when security code is 1:0, or after a key match or erased blank check; else secured.
// - At reset the option byte is copied into the working option register.
// - Erased option byte (code 1:1) leaves the device secured.
// - Debug module cannot be enabled while secured.
// - Backdoor enable clear makes the key mechanism unusable.
// - In key access mode key location writes are captured, not commands.
// - Leaving key mode with matching key unsecures until next reset.
// - Key writes accepted only from secure code, never from debug.
// - Protection register writable only by debug commands.
// - Blank check finding flash erased unsecures until next reset.
// - Prescaler bit 7 read-only; bits 6:0 take only the first write.
// - Loaded flag set by first write; program/erase disabled while clear.
// - Prescale bit selects bus clock or bus clock divided by eight.
// - Timing clock is divider input over ratio plus one.
// - Timing pulse lasts one bus clock cycle, once per flash clock period.
// - Flash write before prescaler written sets the access error flag.
// - Security code in option bits 1:0, backdoor enable in bit 7.
module fsp_security (
   input  wire logic        hclk,               // Bus clock, 100 MHz
   input  wire logic        hresetn,            // Async reset, active low
   input  wire logic        clk_en,             // Freezes all state when low
   input  wire logic        hsel,               // Slave select
   input  wire logic [31:0] haddr,              // Byte address
   input  wire logic [1:0]  htrans,             // Transfer type
   input  wire logic        hwrite,             // Write when high
   input  wire logic [2:0]  hsize,              // Word only
   input  wire logic [31:0] hwdata,             // Write data
   input  wire logic        hready,             // Bus ready
   input  wire logic        bus_from_secure,    // Access from secure code
   input  wire logic        bus_from_debug,     // Access from debug commands
   output logic [31:0]      hrdata,             // Read data
   output logic             hreadyout,          // Always ready
   output logic             hresp,              // Always OKAY
   input  wire logic [7:0]  nv_option_byte,     // Nonvolatile option byte
   input  wire logic [7:0]  nv_protection_byte, // Nonvolatile protection byte
   input  wire logic [63:0] backdoor_key_bytes, // Stored key, byte 0 low
   input  wire logic        blank_check_done,   // Blank check finished pulse
   input  wire logic        blank_check_erased, // Flash found erased
   input  wire logic        mem_req,            // Flash/RAM access request
   input  wire logic        mem_write,          // Request is a write
   input  wire logic        mem_from_secure,    // Request from secure code
   input  wire logic        mem_from_debug,     // Request from debug interface
   input  wire logic [7:0]  mem_rdata_in,       // Raw memory read data
   output logic             mem_grant,          // Access allowed, delayed a cycle
   output logic [7:0]       mem_rdata,          // Gated read data
   output logic             flash_cmd_start,    // Flash write accepted pulse
   output logic             prog_erase_enable,  // Divider loaded
   output logic             flash_timing_pulse, // Flash clock strobe
   output logic             secured,            // Security engaged
   output logic             debug_module_enable // On-chip debug enabled
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic                 dp_valid, dp_write, dp_secure, dp_debug;
   logic [7:0]           dp_addr;
   logic                 opt_loaded, sec_override, key_mode, acc_err, div_loaded;
   logic [6:0]           div_setting;
   logic [7:0]           option, protection;
   logic [7:0]           key_entry [fsp_pkg::KEY_BYTES];
   logic [7:0]           key_seen;
   logic [fsp_pkg::KEY_BYTES-1:0] key_hit;

   logic                 next_dp_valid, next_dp_write, next_dp_secure, next_dp_debug;
   logic [7:0]           next_dp_addr;
   logic                 next_opt_loaded, next_sec_override, next_key_mode, next_acc_err;
   logic                 next_div_loaded, next_secured, next_dbg_en, next_cmd_start;
   logic [6:0]           next_div_setting;
   logic [7:0]           next_option, next_protection, next_key_seen;
   logic [7:0]           next_key_entry [fsp_pkg::KEY_BYTES];
   logic [31:0]          next_hrdata;
   logic                 next_mem_grant;
   logic [7:0]           next_mem_rdata;
   logic                 wr, key_addr, flash_addr, key_ok, mem_ok;
   logic [7:0]           wb;
   logic [2:0]           key_idx;

   // Per key byte compare against the stored key
   genvar gi;
   generate
      for (gi = 0; gi < fsp_pkg::KEY_BYTES; gi++) begin : g_key
         assign key_hit[gi] = (key_entry[gi] == backdoor_key_bytes[8*gi +: 8]);
      end
   endgenerate

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   // Bus data phase effects, option load and security decisions
   always_comb begin
      next_dp_valid     = hsel && htrans[1] && hready;
      next_dp_write     = hwrite;
      next_dp_addr      = haddr[7:0];
      next_dp_secure    = bus_from_secure;
      next_dp_debug     = bus_from_debug;
      next_opt_loaded   = 1'b1;
      next_option       = option;
      next_protection   = protection;
      next_sec_override = sec_override;
      next_key_mode     = key_mode;
      next_acc_err      = acc_err;
      next_div_loaded   = div_loaded;
      next_div_setting  = div_setting;
      next_key_seen     = key_seen;
      next_key_entry    = key_entry;
      next_cmd_start    = 1'b0;
      next_dbg_en       = debug_module_enable;
      wr                = dp_valid && dp_write;
      wb                = hwdata[7:0];
      key_idx           = dp_addr[4:2];
      key_addr          = (dp_addr[7:5] == fsp_pkg::OFS_KEY_BASE[7:5]);
      flash_addr        = dp_addr[7];
      key_ok            = dp_secure && !dp_debug;
      // Working copies taken once, in the first enabled cycle after reset
      if (!opt_loaded) begin
         next_option     = nv_option_byte;
         next_protection = nv_protection_byte;
      end
      if (wr) begin
         if (dp_addr == fsp_pkg::OFS_PRESCALER && !div_loaded) begin
            next_div_setting = wb[6:0];
            next_div_loaded  = 1'b1;
         end
         if (dp_addr == fsp_pkg::OFS_PROTECTION && dp_debug) begin
            next_protection = wb;
         end
         if (dp_addr == fsp_pkg::OFS_DEBUG) begin
            next_dbg_en = wb[fsp_pkg::DBG_ENABLE_BIT];
         end
         if (dp_addr == fsp_pkg::OFS_CONFIG) begin
            next_key_mode = wb[fsp_pkg::CFG_KEY_ACCESS_MODE_BIT];
            // Compare on leaving key mode; a mismatch only clears the seen flags
            if (key_mode && !wb[fsp_pkg::CFG_KEY_ACCESS_MODE_BIT]) begin
               if (option[fsp_pkg::OPT_BACKDOOR_BIT] && (&key_seen) && (&key_hit)) begin
                  next_sec_override = 1'b1;
               end
               next_key_seen = 8'h00;
            end
         end
         // Key writes in key mode are captured, never commands
         if (key_addr && key_mode) begin
            if (key_ok) begin
               next_key_entry[key_idx] = wb;
               next_key_seen[key_idx]  = 1'b1;
            end
         end else if (flash_addr || key_addr) begin
            if (!div_loaded) begin
               next_acc_err = 1'b1;
            end else if (!acc_err && (!secured || key_ok)) begin
               next_cmd_start = 1'b1;
            end
         end
         // Write 1 clears; a same-cycle new error above still wins
         if (dp_addr == fsp_pkg::OFS_STATUS && wb[fsp_pkg::STAT_ACCERR_BIT] && !next_acc_err) begin
            next_acc_err = 1'b0;
         end else if (dp_addr == fsp_pkg::OFS_STATUS && wb[fsp_pkg::STAT_ACCERR_BIT]
                      && !(flash_addr || key_addr)) begin
            next_acc_err = 1'b0;
         end
      end
      if (blank_check_done && blank_check_erased) begin
         next_sec_override = 1'b1;
      end
      next_secured = next_sec_override ? 1'b0
                   : (next_option[1:0] != fsp_pkg::SEC_UNSECURED);
      if (next_secured) begin
         next_dbg_en = 1'b0;
      end
   end

   // Memory gate: secure code always passes, others only when unsecured
   always_comb begin
      mem_ok         = (mem_from_secure && !mem_from_debug) || !secured;
      next_mem_grant = mem_req && mem_ok;
      next_mem_rdata = (mem_req && !mem_write && mem_ok) ? mem_rdata_in : 8'h00;
   end

   // Read mux from next values so a read right after a write sees it
   always_comb begin
      next_hrdata = 32'h0000_0000;
      if (next_dp_valid && !hwrite) begin
         case (haddr[7:0])
            fsp_pkg::OFS_PRESCALER:  next_hrdata = {24'h00_0000, next_div_loaded, next_div_setting};
            fsp_pkg::OFS_OPTION:     next_hrdata = {24'h00_0000, next_option[7:2],
                                       next_sec_override ? fsp_pkg::SEC_UNSECURED : next_option[1:0]};
            fsp_pkg::OFS_CONFIG:     next_hrdata = {26'h000_0000, next_key_mode, 5'h00};
            fsp_pkg::OFS_PROTECTION: next_hrdata = {24'h00_0000, next_protection};
            fsp_pkg::OFS_STATUS:     next_hrdata = {29'h0000_0000, next_div_loaded, next_secured, next_acc_err};
            fsp_pkg::OFS_DEBUG:      next_hrdata = {31'h0000_0000, next_dbg_en};
            default:                 next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   // Reset takes constants; option byte arrives in the first enabled cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid            <= 1'b0;
         dp_write            <= 1'b0;
         dp_addr             <= 8'h00;
         dp_secure           <= 1'b0;
         dp_debug            <= 1'b0;
         opt_loaded          <= 1'b0;
         option              <= fsp_pkg::OPTION_RESET;
         protection          <= fsp_pkg::PROT_RESET;
         sec_override        <= 1'b0;
         key_mode            <= 1'b0;
         acc_err             <= 1'b0;
         div_loaded          <= 1'b0;
         div_setting         <= fsp_pkg::PRESC_RESET;
         key_seen            <= 8'h00;
         for (int i = 0; i < fsp_pkg::KEY_BYTES; i++) begin
            key_entry[i] <= fsp_pkg::KEY_RESET;
         end
         flash_cmd_start     <= 1'b0;
         secured             <= 1'b1;
         debug_module_enable <= 1'b0;
         hrdata              <= 32'h0000_0000;
         hreadyout           <= 1'b1;
         hresp               <= 1'b0;
         mem_grant           <= 1'b0;
         mem_rdata           <= 8'h00;
         prog_erase_enable   <= 1'b0;
      end else if (clk_en) begin
         dp_valid            <= next_dp_valid;
         dp_write            <= next_dp_write;
         dp_addr             <= next_dp_addr;
         dp_secure           <= next_dp_secure;
         dp_debug            <= next_dp_debug;
         opt_loaded          <= next_opt_loaded;
         option              <= next_option;
         protection          <= next_protection;
         sec_override        <= next_sec_override;
         key_mode            <= next_key_mode;
         acc_err             <= next_acc_err;
         div_loaded          <= next_div_loaded;
         div_setting         <= next_div_setting;
         key_seen            <= next_key_seen;
         key_entry           <= next_key_entry;
         flash_cmd_start     <= next_cmd_start;
         secured             <= next_secured;
         debug_module_enable <= next_dbg_en;
         hrdata              <= next_hrdata;
         hreadyout           <= 1'b1;
         hresp               <= 1'b0;
         mem_grant           <= next_mem_grant;
         mem_rdata           <= next_mem_rdata;
         prog_erase_enable   <= next_div_loaded;
      end
   end

   // Timing strobe generator, held until the divider is loaded
   fsp_clk_div u_div (
      .hclk              (hclk),
      .hresetn           (hresetn),
      .clk_en            (clk_en),
      .run               (div_loaded),
      .prescale_by_eight (div_setting[fsp_pkg::PRESC_BY8_BIT]),
      .ratio             (div_setting[5:0]),
      .timing_pulse      (flash_timing_pulse)
   );

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_key_exit;
      $fell(key_mode);
   endsequence

   property p_block_read;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && mem_req && !mem_write && secured && mem_from_debug) |=> (mem_rdata == 8'h00);
   endproperty
   a_block_read: assert property (p_block_read) else $error("blocked read returned data");

   property p_secure_pass;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && mem_req && mem_from_secure && !mem_from_debug) |=> mem_grant;
   endproperty
   a_secure_pass: assert property (p_secure_pass) else $error("secure access not granted");

   property p_option_load;
      @(posedge hclk) disable iff (!hresetn)
      $rose(opt_loaded) |-> (option == $past(nv_option_byte));
   endproperty
   a_option_load: assert property (p_option_load) else $error("option byte not copied");

   property p_erased_secure;
      @(posedge hclk) disable iff (!hresetn)
      (opt_loaded && !sec_override && option[1:0] != fsp_pkg::SEC_UNSECURED) |-> secured;
   endproperty
   a_erased_secure: assert property (p_erased_secure) else $error("not secured");

   property p_dbg_refuse;
      @(posedge hclk) disable iff (!hresetn)
      secured |-> !debug_module_enable;
   endproperty
   a_dbg_refuse: assert property (p_dbg_refuse) else $error("debug enabled while secured");

   property p_no_key;
      @(posedge hclk) disable iff (!hresetn)
      s_key_exit and (!option[fsp_pkg::OPT_BACKDOOR_BIT] && !$past(sec_override)
                      && !$past(blank_check_done)) |-> !sec_override;
   endproperty
   a_no_key: assert property (p_no_key) else $error("disabled key unlocked");

   property p_key_unlock;
      @(posedge hclk) disable iff (!hresetn)
      s_key_exit and ($past(option[fsp_pkg::OPT_BACKDOOR_BIT] && (&key_seen) && (&key_hit))) |-> !secured;
   endproperty
   a_key_unlock: assert property (p_key_unlock) else $error("matching key did not unlock");

   property p_presc_once;
      @(posedge hclk) disable iff (!hresetn)
      $past(div_loaded) |-> $stable(div_setting);
   endproperty
   a_presc_once: assert property (p_presc_once) else $error("prescaler rewritten");

   property p_loaded_gate;
      @(posedge hclk) disable iff (!hresetn)
      !div_loaded |-> (!flash_cmd_start && !flash_timing_pulse) ##1 !prog_erase_enable || div_loaded;
   endproperty
   a_loaded_gate: assert property (p_loaded_gate) else $error("program enabled before load");

   property p_blank;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && blank_check_done && blank_check_erased) |=> !secured;
   endproperty
   a_blank: assert property (p_blank) else $error("blank check did not unlock");

   property p_acc_err;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr && dp_addr[7] && !div_loaded) |=> acc_err;
   endproperty
   a_acc_err: assert property (p_acc_err) else $error("access error not flagged");

endmodule
`default_nettype wire

//--- fsp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bus-side host: CPU and debug controller
// ----
module fsp_host (
   input  wire logic        hclk,   // Bus clock
   input  wire logic        hready, // Slave ready
   input  wire logic [31:0] hrdata, // Read data
   output logic             hsel,   // Select
   output logic [31:0]      haddr,  // Address
   output logic [1:0]       htrans, // Transfer type
   output logic             hwrite, // Write
   output logic [31:0]      hwdata, // Write data
   output logic             sec,    // From secure code
   output logic             dbg     // From debug commands
);
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, sec, dbg} = '0;
   end
   // One word, each phase held until ready
   task automatic xfer(input logic w, input logic [7:0] a, d, input logic s, g, output logic [7:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      sec <= s;
      dbg <= g;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata[7:0];
   endtask
   // Key entry; an idle cycle keeps key writes apart
   task automatic key(input logic g, input logic [63:0] k);
      logic [7:0] q;
      xfer(1'b1, fsp_pkg::OFS_CONFIG, 8'h20, ~g, g, q);
      for (int i = 0; i < fsp_pkg::KEY_BYTES; i++) begin
         xfer(1'b1, fsp_pkg::OFS_KEY_BASE + 8'(4 * i), k[8*i +: 8], ~g, g, q);
         @(posedge hclk);
      end
      xfer(1'b1, fsp_pkg::OFS_CONFIG, 8'h00, ~g, g, q);
   endtask
endmodule
`default_nettype wire

//--- flash_security_and_clock_prescale_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench: register, gate, key and divider tests
// ----
module flash_security_and_clock_prescale_tb_top;
   localparam logic [63:0] KEY = 64'h0123456789abcdef;
   logic hclk = 1'b0, hresetn = 1'b0, bc_done = 1'b0, bc_erased = 1'b0, mem_req = 1'b0;
   logic m_sec = 1'b0, m_dbg = 1'b0, hsel, hwrite, sec, dbg, hreadyout, hresp, mem_grant;
   logic pe_en, pulse, secured, dbg_en, cmd_start, m_wr = 1'b0;
   logic [7:0] nv_opt = 8'hff, mem_rdata_in = 8'h5a, mem_rdata;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   int err_total = 0, n_compared = 0;
   always #5 hclk = ~hclk;
   fsp_host i_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hwdata, .sec, .dbg);
   fsp_security i_dut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .bus_from_secure(sec), .bus_from_debug(dbg), .hrdata, .hreadyout, .hresp,
      .nv_option_byte(nv_opt), .nv_protection_byte(8'hf8), .backdoor_key_bytes(KEY), .blank_check_done(bc_done),
      .blank_check_erased(bc_erased), .mem_req, .mem_write(m_wr), .mem_from_secure(m_sec), .mem_from_debug(m_dbg),
      .mem_rdata_in, .mem_grant, .mem_rdata, .flash_cmd_start(cmd_start), .prog_erase_enable(pe_en),
      .flash_timing_pulse(pulse), .secured, .debug_module_enable(dbg_en));
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Settled look at the security flag, then back on an edge
   task automatic sec_is(input logic exp);
      @(posedge hclk);
      #1 chk("secured", {15'h0, secured}, {15'h0, exp});
      @(posedge hclk);
   endtask
   task automatic rst(input logic [7:0] nv);
      hresetn <= 1'b0;
      nv_opt <= nv;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask
   // Read from memory through the gate; blocked reads give zero
   task automatic mchk(input logic s, g, exp);
      mem_req <= 1'b1;
      m_sec <= s;
      m_dbg <= g;
      @(posedge hclk);
      mem_req <= 1'b0;
      #1 chk("grant", {15'h0, mem_grant}, {15'h0, exp});
      chk("mem_rdata", {8'h0, mem_rdata}, exp ? 16'h005a : 16'h0000);
      @(posedge hclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic g, input logic [7:0] exp);
      logic [7:0] q;
      i_host.xfer(1'b0, a, 8'h00, ~g, g, q);
      chk("register", {8'h0, q}, {8'h0, exp});
   endtask
   initial begin
      logic [7:0] q;
      int n;
      rst(8'h83);
      sec_is(1'b1);
      i_host.xfer(1'b1, fsp_pkg::OFS_FLASH_BASE, 8'h11, 1'b1, 1'b0, q);
      #1 chk("cmd_start", {15'h0, cmd_start}, 16'h0000);
      @(posedge hclk);
      rd(fsp_pkg::OFS_STATUS, 1'b0, 8'h03);
      i_host.xfer(1'b1, fsp_pkg::OFS_STATUS, 8'h01, 1'b1, 1'b0, q);
      rd(fsp_pkg::OFS_PRESCALER, 1'b0, 8'h00);
      chk("pe_en", {15'h0, pe_en}, 16'h0000);
      i_host.xfer(1'b1, fsp_pkg::OFS_PRESCALER, 8'h7e, 1'b1, 1'b0, q);
      i_host.xfer(1'b1, fsp_pkg::OFS_PRESCALER, 8'h01, 1'b1, 1'b0, q);
      rd(fsp_pkg::OFS_PRESCALER, 1'b0, 8'hfe);
      chk("pe_en", {15'h0, pe_en}, 16'h0001);
      // Loaded divider: a secure flash write becomes a command step
      i_host.xfer(1'b1, fsp_pkg::OFS_FLASH_BASE, 8'h22, 1'b1, 1'b0, q);
      #1 chk("cmd_start", {15'h0, cmd_start}, 16'h0001);
      @(posedge hclk);
      i_host.xfer(1'b1, fsp_pkg::OFS_FLASH_BASE, 8'h33, 1'b0, 1'b0, q);
      #1 chk("cmd_start", {15'h0, cmd_start}, 16'h0000);
      @(posedge hclk);
      // Period between strobes: 8 x (62 + 1) bus cycles
      n = 0;
      do begin @(posedge hclk); #1 n++; end while (pulse !== 1'b1 && n < 600);
      n = 0;
      do begin @(posedge hclk); #1 n++; end while (pulse !== 1'b1 && n < 600);
      chk("pulse period", 16'(n), 16'd504);
      @(posedge hclk);
      mchk(1'b0, 1'b0, 1'b0);
      mchk(1'b0, 1'b1, 1'b0);
      m_wr <= 1'b1;
      mchk(1'b0, 1'b0, 1'b0);
      m_wr <= 1'b0;
      mchk(1'b1, 1'b0, 1'b1);
      i_host.xfer(1'b1, fsp_pkg::OFS_DEBUG, 8'h01, 1'b1, 1'b0, q);
      rd(fsp_pkg::OFS_DEBUG, 1'b0, 8'h00);
      chk("dbg_en", {15'h0, dbg_en}, 16'h0000);
      i_host.xfer(1'b1, fsp_pkg::OFS_PROTECTION, 8'h00, 1'b1, 1'b0, q);
      rd(fsp_pkg::OFS_PROTECTION, 1'b0, 8'hf8);
      chk("hresp", {15'h0, hresp}, 16'h0000);
      i_host.xfer(1'b1, fsp_pkg::OFS_PROTECTION, 8'h5a, 1'b0, 1'b1, q);
      rd(fsp_pkg::OFS_PROTECTION, 1'b1, 8'h5a);
      i_host.key(1'b1, KEY);
      sec_is(1'b1);
      i_host.key(1'b0, ~KEY);
      sec_is(1'b1);
      i_host.key(1'b0, KEY);
      sec_is(1'b0);
      rd(fsp_pkg::OFS_OPTION, 1'b0, 8'h82);
      mchk(1'b0, 1'b1, 1'b1);
      i_host.xfer(1'b1, fsp_pkg::OFS_DEBUG, 8'h01, 1'b1, 1'b0, q);
      rd(fsp_pkg::OFS_DEBUG, 1'b0, 8'h01);
      chk("dbg_en", {15'h0, dbg_en}, 16'h0001);
      rst(8'h03);
      i_host.key(1'b0, KEY);
      sec_is(1'b1);
      bc_done <= 1'b1;
      bc_erased <= 1'b1;
      @(posedge hclk);
      bc_done <= 1'b0;
      sec_is(1'b0);
      // Option byte with low security bit programmed to 0 stays open
      rst(8'h82);
      sec_is(1'b0);
      stop_test();
   end
   // Watchdog well beyond the expected 1200 or so cycles
   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
